// ==== rtl/fetch_pkg.sv ====
package fetch_pkg;
  localparam int          PC_W          = 12;
  localparam int          PCL_W         = 8;
  localparam int          PHASES        = 4;
  localparam logic [11:0] PC_RESET      = 12'h000;
  localparam logic [11:0] REG_PCL       = 12'h000;  // byte address of the low byte register
  localparam logic [11:0] REG_STATUS    = 12'h004;  // byte address of the status register
  localparam int          ST_FLUSH_BIT  = 0;
  localparam int          ST_PHASE_LSB  = 1;
  localparam int          ST_PCH_LSB    = 4;
  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} phase_t;
endpackage

// ==== rtl/phase_gen.sv ====
`timescale 1ns/1ps
// four-phase strobe generator
module phase_gen
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // phase outputs
  output fetch_pkg::phase_t      phase,
  output logic [3:0]             phase_clocks
);
  fetch_pkg::phase_t phase_q;
  fetch_pkg::phase_t phase_d;

  // rotate through the four phases
  always_comb
  begin
    case (phase_q)
      fetch_pkg::PH_T1: phase_d = fetch_pkg::PH_T2;
      fetch_pkg::PH_T2: phase_d = fetch_pkg::PH_T3;
      fetch_pkg::PH_T3: phase_d = fetch_pkg::PH_T4;
      default:          phase_d = fetch_pkg::PH_T1;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      phase_q <= fetch_pkg::PH_T1;
    else if (clk_en)
      phase_q <= phase_d;
  end

  // one-hot strobes never overlap since they decode one state
  assign phase        = phase_q;
  assign phase_clocks = 4'h1 << phase_q;
endmodule

// ==== rtl/fetch_pipeline_program_counter.sv ====
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
// instruction fetch pipeline and program counter
module fetch_pipeline_program_counter #(
  parameter int INSTR_W = 15
)
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  // program memory
  output logic [11:0]                fetch_addr,
  output logic                       fetch_strobe,
  input  wire logic [INSTR_W-1:0]    fetch_data,
  // decode and execute side
  output logic [INSTR_W-1:0]         exec_instr,
  output logic                       exec_valid,
  output logic [3:0]                 instruction_phase_clocks,
  input  wire logic                  branch_req,
  input  wire logic [11:0]           branch_target,
  input  wire logic                  skip_taken,
  input  wire logic                  irq_entry,
  input  wire logic [11:0]           irq_vector,
  // avalon-mm slave
  input  wire logic [11:0]           avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest
);
  fetch_pkg::phase_t phase;

  phase_gen u_phase
  (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .clk_en       (clk_en),
    .phase        (phase),
    .phase_clocks (instruction_phase_clocks)
  );

  logic [11:0]        pc_q;
  logic [11:0]        pc_d;
  logic [INSTR_W-1:0] instr_q;
  logic [INSTR_W-1:0] instr_d;
  logic               valid_q;
  logic               valid_d;
  logic               flush_q;
  logic               flush_d;
  logic               pcl_wr_q;
  logic               pcl_wr_d;
  logic [7:0]         pcl_new_q;
  logic [7:0]         pcl_new_d;
  logic               ack_q;
  logic               ack_d;
  logic [31:0]        rdata_q;
  logic [31:0]        rdata_d;
  logic               branch_pend_q;
  logic               branch_pend_d;
  logic [11:0]        target_q;
  logic [11:0]        target_d;

  // same-page target built from the current high part
  function automatic logic [11:0] page_jump(input logic [11:0] pc, input logic [7:0] lo);
    page_jump = {pc[11:8], lo};
  endfunction

  wire is_t1  = (phase == fetch_pkg::PH_T1);
  wire is_t4  = (phase == fetch_pkg::PH_T4);
  wire access = avs_read | avs_write;

  // bus access: answer one cycle after request, pcl write queued to next cycle boundary
  always_comb
  begin
    ack_d     = access & ~ack_q;
    rdata_d   = rdata_q;
    pcl_wr_d  = pcl_wr_q;
    pcl_new_d = pcl_new_q;
    // a queued write is consumed at T4; cleared first so a write landing now still wins
    if (pcl_wr_q && is_t4)
      pcl_wr_d = 1'b0;
    if (access & ~ack_q)
    begin
      if (avs_read)
      begin
        case (avs_address)
          fetch_pkg::REG_PCL:    rdata_d = {24'h00_0000, pc_q[7:0]};
          fetch_pkg::REG_STATUS: rdata_d = {24'h00_0000, pc_q[11:8], 1'b0, phase, flush_q};
          default:               rdata_d = 32'h0000_0000;
        endcase
      end
      else if (avs_address == fetch_pkg::REG_PCL && avs_byteenable[0])
      begin
        pcl_wr_d  = 1'b1;
        pcl_new_d = avs_writedata[7:0];
      end
    end
  end

  // pipeline: counter advances at T1 while the fetched word moves into execute
  always_comb
  begin
    pc_d          = pc_q;
    instr_d       = instr_q;
    valid_d       = valid_q;
    flush_d       = flush_q;
    branch_pend_d = branch_pend_q;
    target_d      = target_q;
    if (is_t1)
    begin
      instr_d = fetch_data;
      valid_d = ~flush_q;
      flush_d = 1'b0;
      pc_d    = pc_q + 12'h001;
    end
    if (branch_req && is_t4 && !branch_pend_q)
    begin
      branch_pend_d = 1'b1;
      target_d      = branch_target;
    end
    // redirects decided at end of execute so the wrong word is flushed
    if (is_t4)
    begin
      if (irq_entry)
      begin
        pc_d    = irq_vector;
        flush_d = 1'b1;
      end
      else if (branch_pend_q)
      begin
        pc_d          = target_q;
        flush_d       = 1'b1;
        branch_pend_d = 1'b0;
      end
      else if (pcl_wr_q)
      begin
        pc_d    = page_jump(pc_q, pcl_new_q);
        flush_d = 1'b1;
      end
      else if (skip_taken)
        flush_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pc_q          <= fetch_pkg::PC_RESET;
      instr_q       <= '0;
      valid_q       <= 1'b0;
      flush_q       <= 1'b1;
      pcl_wr_q      <= 1'b0;
      pcl_new_q     <= 8'h00;
      ack_q         <= 1'b0;
      rdata_q       <= 32'h0000_0000;
      branch_pend_q <= 1'b0;
      target_q      <= 12'h000;
    end
    else if (clk_en)
    begin
      pc_q          <= pc_d;
      instr_q       <= instr_d;
      valid_q       <= valid_d;
      flush_q       <= flush_d;
      pcl_wr_q      <= pcl_wr_d;
      pcl_new_q     <= pcl_new_d;
      ack_q         <= ack_d;
      rdata_q       <= rdata_d;
      branch_pend_q <= branch_pend_d;
      target_q      <= target_d;
    end
  end

  // the counter addresses memory during the whole INSTRUCTION_PHASE_CLOCKS fetch window
  assign fetch_addr      = pc_q;
  assign fetch_strobe    = is_t1;
  assign exec_instr      = instr_q;
  assign exec_valid      = valid_q;
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = access & ~(ack_q & clk_en);
endmodule

// ==== verif/fetch_props.sv ====
`timescale 1ns/1ps
// pipeline and bus checks on the top-level ports
module fetch_props
(
  // clock, reset, fetch side
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic [11:0] fetch_addr,
  input wire logic        fetch_strobe,
  input wire logic [3:0]  instruction_phase_clocks,
  // register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [11:0] avs_address,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // counting edge of T1; a request not yet answered
  // sampled reset excludes the releasing edge, where the counter is still held
  sequence s_t1; !rst && clk_en && instruction_phase_clocks[0]; endsequence
  sequence s_req; clk_en && (avs_read || avs_write) && avs_waitrequest; endsequence
  a_phase_onehot: assert property ($onehot(instruction_phase_clocks))
    else $error("phases not one-hot");
  a_phase_wrap: assert property (clk_en && instruction_phase_clocks[3] |=> instruction_phase_clocks[0])
    else $error("T4 not followed by T1");
  a_strobe_in_t1: assert property (fetch_strobe == instruction_phase_clocks[0])
    else $error("strobe outside T1");
  a_pc_step: assert property (s_t1 |=> fetch_addr == $past(fetch_addr) + 12'h001)
    else $error("no step after T1");
  a_pc_hold: assert property (clk_en && (instruction_phase_clocks[1] || instruction_phase_clocks[2])
    |=> $stable(fetch_addr)) else $error("counter moved in T2 or T3");
  // on a T1 step the high part may only move on a carry out of the low byte
  a_page_kept: assert property ((s_t1 and fetch_addr[7:0] != 8'hff) |=> $stable(fetch_addr[11:8]))
    else $error("page bits changed");
  a_one_wait: assert property (s_req |=> !avs_waitrequest)
    else $error("bus answer late");
  a_pcl_upper: assert property (avs_read && !avs_waitrequest && avs_address == fetch_pkg::REG_PCL
    |-> avs_readdata[31:8] == 24'h00_0000) else $error("upper read bits set");
endmodule
bind fetch_pipeline_program_counter fetch_props i_fetch_props (.*);

// ==== verif/prog_mem_model.sv ====
`timescale 1ns/1ps
// program memory: word follows address; inverted outside T1 so a late sample fails
module prog_mem_model
(
  input  wire logic [11:0] fetch_addr,
  input  wire logic        fetch_strobe,
  output logic [14:0]      fetch_data
);
  assign fetch_data = fetch_strobe ? {3'h0, fetch_addr} : ~{3'h0, fetch_addr};
endmodule

// ==== verif/fetch_pipeline_program_counter_tb.sv ====
`timescale 1ns/1ps
module fetch_pipeline_program_counter_tb;
  logic        ref_clk, rst, clk_en, fetch_strobe, exec_valid, branch_req, skip_taken, irq_entry;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [11:0] fetch_addr, branch_target, irq_vector, avs_address;
  logic [14:0] fetch_data, exec_instr;
  logic [3:0]  instruction_phase_clocks, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdd;
  int          n_fail, tests_run, n;
  fetch_pipeline_program_counter i_fetch_pipeline_program_counter (.*);
  prog_mem_model i_prog_mem_model (.*);
  // 40 MHz
  initial
  begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task stop_test;
    $display("mismatches %0d of %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // a wait that runs out of its bound is a failure
  task tmo;
    n_fail++;
    $display("Error %0t: wait timed out", $time);
    stop_test;
  endtask
  // bus access held until waitrequest is seen low at an edge
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge ref_clk);
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= {!w, w, a, d, b};
    n = 0;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0 && ++n < 20);
    rdd = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
    if (n >= 20)
      tmo;
  endtask
  // k: 0 branch, 1 interrupt, 2 skip; raised for T4, then e edges waited
  task ctl(input int k, input logic [11:0] t, input int e);
    n = 0;
    do @(posedge ref_clk); while (instruction_phase_clocks !== 4'h4 && ++n < 8);
    if (n >= 8)
      tmo;
    {branch_req, irq_entry, skip_taken, branch_target, irq_vector} <= {k == 0, k == 1, k == 2, t, t};
    @(posedge ref_clk);
    {branch_req, irq_entry, skip_taken} <= 3'b000;
    repeat (e) @(posedge ref_clk);
    #1;
  endtask
  // bounded wait on the low byte (k 0) or a dummy slot (k 1)
  task till(input int k);
    for (n = 0; n < 12 && (k ? exec_valid !== 1'b0 : fetch_addr[7:0] !== 8'h12); n++)
      @(posedge ref_clk) #1;
    if (n >= 12)
      tmo;
  endtask
  initial
  begin
    {rst, clk_en, branch_req, skip_taken, irq_entry, avs_read, avs_write} = 7'h60;
    {branch_target, irq_vector, avs_address, avs_writedata, avs_byteenable} = '0;
    {n_fail, tests_run} = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    #1;
    chk(fetch_addr, 0);
    chk(exec_valid, 0);
    acc(0, fetch_pkg::REG_PCL, 0, 4'hf);
    chk(rdd[31:8], 0);
    acc(0, 12'h008, 0, 4'hf);
    chk(rdd, 0);
    ctl(1, 12'h3f0, 0);
    chk(fetch_addr, 12'h3f0);
    ctl(0, 12'h5a0, 4);
    chk(fetch_addr, 12'h5a0);
    // let the branch dummy slot pass so the next dummy can only come from the low byte write
    repeat (8) @(posedge ref_clk);
    acc(1, fetch_pkg::REG_PCL, 32'hffff_ff12, 4'h1);
    till(0);
    chk(fetch_addr, 12'h512);
    till(1);
    chk(n < 12, 1);
    chk(exec_instr, 32'h0000_0512);
    acc(0, fetch_pkg::REG_STATUS, 0, 4'hf);
    chk(rdd[7:4], 4'h5);
    acc(1, fetch_pkg::REG_PCL, 32'h0000_0077, 4'h0);
    repeat (8) @(posedge ref_clk);
    chk(fetch_addr[7:0] == 8'h77, 0);
    ctl(2, 12'h000, 0);
    till(1);
    chk(n < 12, 1);
    // clock enable low for a full phase round: the counter must not move
    @(posedge ref_clk);
    clk_en <= 1'b0;
    #1 rdd = fetch_addr;
    repeat (4) @(posedge ref_clk);
    clk_en <= 1'b1;
    #1;
    chk(fetch_addr, rdd);
    stop_test;
  end
endmodule
